/* hps_pkg.sv */
package hps_pkg;
    // Register byte addresses on the plain port (status offsets are chosen).
    localparam logic [7:0] PORT_E_STATUS_ADDR  = 8'hCB;
    localparam logic [7:0] PORT_E_CONTROL_ADDR = 8'hCC;
    localparam logic [7:0] PORT_E_DATA_ADDR    = 8'hC8;
    localparam logic [7:0] PORT_F_STATUS_ADDR  = 8'hDB;
    localparam logic [7:0] PORT_F_CONTROL_ADDR = 8'hDC;
    localparam logic [7:0] PORT_F_DATA_ADDR    = 8'hD8;
    // Status field positions.
    localparam int ST_RXFULL_BIT  = 7;
    localparam int ST_RXCODE_HI   = 6;
    localparam int ST_OVERRUN_BIT = 5;
    localparam int ST_RXCODE_LO   = 4;
    localparam int ST_TXFULL_BIT  = 3;
    localparam int ST_CAUSE_HI    = 2;
    localparam int ST_CAUSE_LO    = 1;
    localparam int ST_SHORT_BIT   = 0;
    // Control command and mode fields.
    localparam int CT_CMD_HI = 7;
    localparam int CT_CMD_LO = 6;
    localparam int CT_MODE_HI = 3;
    localparam int CT_MODE_LO = 2;
    localparam logic [1:0] CMD_NONE  = 2'h0;
    localparam logic [1:0] CMD_HUNT  = 2'h1;
    localparam logic [1:0] CMD_NOP   = 2'h2;
    localparam logic [1:0] CMD_ABORT = 2'h3;
    // Transmit interrupt causes.
    localparam logic [1:0] CAUSE_EMPTY = 2'h0;
    localparam logic [1:0] CAUSE_CRC   = 2'h1;
    localparam logic [1:0] CAUSE_ABORT = 2'h2;
    localparam logic [1:0] CAUSE_FLAG  = 2'h3;
    // Receive codes.
    localparam logic [1:0] RX_DATA    = 2'h0;
    localparam logic [1:0] RX_ABORTED = 2'h1;
    localparam logic [1:0] RX_GOOD    = 2'h2;
    localparam logic [1:0] RX_BAD     = 2'h3;
    // Line patterns and reset values.
    localparam logic [7:0] FLAG_PATTERN  = 8'h7E;
    localparam logic [3:0] ABORT_ONES    = 4'h8;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] MODE_ASYNC    = 2'h0;
endpackage

/* hps_port.sv */
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
// Operation
// - Overrun sets when a received byte is lost; a receive buffer read clears it.
// - Transmit full shows held byte; taking it interrupts unless marked frame end.
// - Transmit buffer write or any status write clears the transmit interrupt.
// - Cause 00 means transmit buffer became empty.
// - End of CRC sends interrupt with cause 01.
// - Data written after CRC interrupt gets exactly one flag, no flag interrupt.
// - End of abort sends interrupt with cause 10.
// - Closing flag gives cause 11; later data gets at least two flags.
// - Width bit reads 0 when buffered received byte has eight bits.
// - Command 01 forces flag search in HDLC mode; 10 does nothing.
// - Command 11 sends an abort in HDLC mode.
// - Receive code: 00 data, 01 aborted, 10 good CRC, 11 bad CRC.
module hps_port (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Register port for this serial port.
    input  wire logic       st_wr,
    input  wire logic       ct_wr,
    input  wire logic       tx_wr,
    input  wire logic       rx_rd,
    input  wire logic [7:0] wdata,
    output logic      [7:0] status,
    output logic      [7:0] control,
    output logic      [7:0] rx_data,
    // Transmit side.
    input  wire logic       tx_last,
    output logic            tx_line,
    output logic            tx_irq,
    // Receive events from the deframer.
    input  wire logic       rx_byte_stb,
    input  wire logic [7:0] rx_byte,
    input  wire logic [1:0] rx_code,
    input  wire logic       rx_short,
    output logic            rx_hunt
);
    typedef enum logic [4:0] {
        HPS_IDLE  = 5'b00001,
        HPS_DATA  = 5'b00010,
        HPS_CRC   = 5'b00100,
        HPS_FLAG  = 5'b01000,
        HPS_ABORT = 5'b10000
    } hps_tx_t;

    hps_tx_t    state_reg;
    logic [7:0] ctl_reg, txbuf_reg, shift_reg, rxbuf_reg;
    logic       txfull_reg, txlast_reg, cur_last_reg, irq_reg, rxfull_reg;
    logic       overrun_reg, short_reg, abort_req_reg, after_crc_reg;
    logic [1:0] cause_reg, rxcode_reg;
    logic [3:0] bit_reg;
    logic [1:0] flags_reg;
    logic       hdlc, take, bit_done, set_irq;
    logic [1:0] set_cause;

    assign hdlc = ctl_reg[hps_pkg::CT_MODE_HI:hps_pkg::CT_MODE_LO] != hps_pkg::MODE_ASYNC;
    assign bit_done = bit_reg == 4'h7;
    // Byte boundary where the transmitter may take a buffered byte.
    assign take = txfull_reg && bit_done && !abort_req_reg &&
                  ((state_reg == HPS_DATA) ||
                   (state_reg == HPS_IDLE && flags_reg == 2'h0));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctl_reg <= hps_pkg::CONTROL_RESET;
        end else if (ct_wr) begin
            ctl_reg <= {hps_pkg::CMD_NONE, wdata[5:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_hunt <= 1'b0;
        end else begin
            rx_hunt <= ct_wr && wdata[hps_pkg::CT_CMD_HI:hps_pkg::CT_CMD_LO] == hps_pkg::CMD_HUNT
                       && wdata[hps_pkg::CT_MODE_HI:hps_pkg::CT_MODE_LO] != hps_pkg::MODE_ASYNC;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            abort_req_reg <= 1'b0;
        end else if (ct_wr && hdlc &&
                     wdata[hps_pkg::CT_CMD_HI:hps_pkg::CT_CMD_LO] == hps_pkg::CMD_ABORT) begin
            abort_req_reg <= 1'b1;
        end else if (bit_done) begin
            abort_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            txfull_reg <= 1'b0;
            txbuf_reg  <= 8'h00;
            txlast_reg <= 1'b0;
        end else if (tx_wr) begin
            txfull_reg <= 1'b1;
            txbuf_reg  <= wdata;
            txlast_reg <= tx_last;
        end else if (take) begin
            txfull_reg <= 1'b0;
        end
    end

    // Transmit sequencer; one serial bit per clock, a byte every eight.
    // flag and abort patterns
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg     <= HPS_IDLE;
            bit_reg       <= 4'h0;
            shift_reg     <= hps_pkg::FLAG_PATTERN;
            flags_reg     <= 2'h0;
            cur_last_reg  <= 1'b0;
            after_crc_reg <= 1'b0;
        end else begin
            bit_reg   <= bit_done ? 4'h0 : bit_reg + 4'h1;
            shift_reg <= {1'b0, shift_reg[7:1]};
            if (bit_done) begin
                if (abort_req_reg) begin
                    state_reg <= HPS_ABORT;
                    shift_reg <= 8'hFF;
                end else if (take) begin
                    state_reg    <= HPS_DATA;
                    shift_reg    <= txbuf_reg;
                    cur_last_reg <= txlast_reg;
                end else begin
                    case (state_reg)
                        HPS_DATA: begin
                            state_reg <= cur_last_reg ? HPS_CRC : HPS_ABORT;
                            shift_reg <= cur_last_reg ? 8'h00 : 8'hFF;
                        end
                        HPS_CRC: begin
                            state_reg     <= HPS_IDLE;
                            shift_reg     <= hps_pkg::FLAG_PATTERN;
                            flags_reg     <= 2'h0;
                            after_crc_reg <= 1'b1;
                        end
                        HPS_ABORT, HPS_IDLE: begin
                            state_reg     <= HPS_IDLE;
                            shift_reg     <= hps_pkg::FLAG_PATTERN;
                            // A closing flag holds new data off for one more flag.
                            flags_reg     <= (state_reg == HPS_ABORT || after_crc_reg) ?
                                             2'h1 : 2'h0;
                            after_crc_reg <= 1'b0;
                        end
                        default: state_reg <= HPS_IDLE;
                    endcase
                end
            end
        end
    end

    always_comb begin
        set_irq   = 1'b0;
        set_cause = hps_pkg::CAUSE_EMPTY;
        if (take && !txlast_reg) begin
            set_irq = 1'b1;
        end else if (bit_done && state_reg == HPS_CRC) begin
            set_irq   = 1'b1;
            set_cause = hps_pkg::CAUSE_CRC;
        end else if (bit_done && state_reg == HPS_ABORT) begin
            set_irq   = 1'b1;
            set_cause = hps_pkg::CAUSE_ABORT;
        end else if (bit_done && state_reg == HPS_IDLE && after_crc_reg && !txfull_reg
                     && flags_reg == 2'h0 && !irq_reg) begin
            // Idle fill flags stay silent; only the flag after a frame's CRC interrupts.
            // closing flag cause
            set_irq   = 1'b1;
            set_cause = hps_pkg::CAUSE_FLAG;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            irq_reg   <= 1'b0;
            cause_reg <= hps_pkg::CAUSE_EMPTY;
        end else if (set_irq) begin
            irq_reg   <= 1'b1;
            cause_reg <= set_cause;
        end else if (tx_wr || st_wr) begin
            irq_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rxfull_reg  <= 1'b0;
            overrun_reg <= 1'b0;
            rxbuf_reg   <= 8'h00;
            rxcode_reg  <= hps_pkg::RX_DATA;
            short_reg   <= 1'b0;
        end else if (rx_byte_stb && rxfull_reg && !rx_rd) begin
            overrun_reg <= 1'b1;
        end else if (rx_byte_stb) begin
            rxfull_reg  <= 1'b1;
            rxbuf_reg   <= rx_byte;
            rxcode_reg  <= rx_code;
            short_reg   <= rx_short;
            overrun_reg <= 1'b0;
        end else if (rx_rd) begin
            rxfull_reg  <= 1'b0;
            overrun_reg <= 1'b0;
        end
    end

    assign status  = {rxfull_reg, rxcode_reg[1], overrun_reg, rxcode_reg[0],
                      txfull_reg, cause_reg, short_reg};
    assign control = ctl_reg;
    assign rx_data = rxbuf_reg;
    assign tx_line = shift_reg[0];
    assign tx_irq  = irq_reg;

    chk_status_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (st_wr && !set_irq) |=> !tx_irq) else $error("status write left irq");
    chk_crc_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        (bit_done && state_reg == HPS_CRC && !(take && !txlast_reg)) |=>
        (tx_irq && status[2:1] == 2'h1)) else $error("crc cause wrong");
    chk_abort_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        (bit_done && state_reg == HPS_ABORT && !take) |=> (tx_irq && status[2:1] == 2'h2))
        else $error("abort cause wrong");
    chk_overrun_set: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_byte_stb && status[7] && !rx_rd) |=> status[5]) else $error("overrun lost");
    chk_overrun_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_rd && !rx_byte_stb) |=> !status[5]) else $error("overrun not cleared");
    chk_txfull_write: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_wr |=> status[3]) else $error("tx full not shown");
    chk_hunt_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        (rx_hunt && !ct_wr) |=> !rx_hunt) else $error("hunt repeated");
    chk_cmd_cleared: assert property (@(posedge mclk) disable iff (sys_rst)
        ct_wr |=> control[7:6] == 2'h0) else $error("command kept");
    sequence s_abort_cmd;
        ct_wr && hdlc && wdata[7:6] == 2'h3;
    endsequence
    chk_abort_ones: assert property (@(posedge mclk) disable iff (sys_rst)
        s_abort_cmd |-> ##[1:9] (state_reg == HPS_ABORT) ##1 tx_line [*7])
        else $error("abort not sent");
    // A closing flag without data waiting, and the bit pattern of a flag on the line.
    sequence s_closing;
        bit_done && state_reg == HPS_IDLE && after_crc_reg && !txfull_reg && !abort_req_reg;
    endsequence
    sequence s_flag_bits;
        !tx_line ##1 tx_line [*6] ##1 !tx_line;
    endsequence
    sequence s_rx_accept;
        rx_byte_stb && !(status[7] && !rx_rd);
    endsequence
    chk_empty_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        (take && !txlast_reg) |=> (tx_irq && status[2:1] == 2'h0))
        else $error("empty cause wrong");
    chk_last_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        (take && txlast_reg && !tx_irq) |=> !tx_irq)
        else $error("frame end byte interrupted");
    chk_txfull_take: assert property (@(posedge mclk) disable iff (sys_rst)
        (take && !tx_wr) |=> !status[3])
        else $error("tx full kept after take");
    chk_data_clear: assert property (@(posedge mclk) disable iff (sys_rst)
        (tx_wr && !set_irq) |=> !tx_irq)
        else $error("data write left irq");
    chk_flag_cause: assert property (@(posedge mclk) disable iff (sys_rst)
        (bit_done && state_reg == HPS_IDLE && after_crc_reg && !txfull_reg && !tx_irq)
        |=> (tx_irq && status[2:1] == 2'h3)) else $error("flag cause wrong");
    chk_two_flags: assert property (@(posedge mclk) disable iff (sys_rst)
        s_closing |-> ##8 !take) else $error("second flag skipped");
    chk_crc_one_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        (bit_done && state_reg == HPS_IDLE && after_crc_reg && txfull_reg && !abort_req_reg)
        |=> (state_reg == HPS_DATA && status[2:1] != 2'h3))
        else $error("extra flag after crc");
    chk_flag_bits: assert property (@(posedge mclk) disable iff (sys_rst)
        (bit_reg == 4'h0 && shift_reg == hps_pkg::FLAG_PATTERN) |-> s_flag_bits)
        else $error("flag pattern wrong");
    chk_abort_length: assert property (@(posedge mclk) disable iff (sys_rst)
        (bit_reg == 4'h0 && state_reg == HPS_ABORT) |-> tx_line [*8])
        else $error("abort too short");
    chk_abort_mode: assert property (@(posedge mclk) disable iff (sys_rst)
        (ct_wr && !hdlc && !abort_req_reg) |=> !abort_req_reg)
        else $error("abort outside hdlc");
    chk_hunt_refused: assert property (@(posedge mclk) disable iff (sys_rst)
        (ct_wr && (wdata[7:6] != 2'h1 || wdata[3:2] == 2'h0)) |=> !rx_hunt)
        else $error("hunt not refused");
    chk_overrun_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (status[5] && !rx_rd) |=> status[5]) else $error("overrun dropped");
    chk_rx_code: assert property (@(posedge mclk) disable iff (sys_rst)
        s_rx_accept |=> ({status[6], status[4]} == $past(rx_code)))
        else $error("receive code wrong");
    chk_short_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        s_rx_accept |=> (status[0] == $past(rx_short)))
        else $error("byte width wrong");
endmodule

/* hps_top.sv */
`timescale 1ns/1ps
module hps_top (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Register port.
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Port E.
    input  wire logic       e_tx_last,
    output logic            e_tx_line,
    output logic            e_tx_irq,
    input  wire logic       e_rx_byte_stb,
    input  wire logic [7:0] e_rx_byte,
    input  wire logic [1:0] e_rx_code,
    input  wire logic       e_rx_short,
    output logic            e_rx_hunt,
    // Port F.
    input  wire logic       f_tx_last,
    output logic            f_tx_line,
    output logic            f_tx_irq,
    input  wire logic       f_rx_byte_stb,
    input  wire logic [7:0] f_rx_byte,
    input  wire logic [1:0] f_rx_code,
    input  wire logic       f_rx_short,
    output logic            f_rx_hunt
);
    logic [7:0] e_st, e_ct, e_rx, f_st, f_ct, f_rx;

    hps_port u_e (
        .mclk(mclk), .sys_rst(sys_rst),
        .st_wr(wr && addr == hps_pkg::PORT_E_STATUS_ADDR),
        .ct_wr(wr && addr == hps_pkg::PORT_E_CONTROL_ADDR),
        .tx_wr(wr && addr == hps_pkg::PORT_E_DATA_ADDR),
        .rx_rd(rd && addr == hps_pkg::PORT_E_DATA_ADDR),
        .wdata(wdata), .status(e_st), .control(e_ct), .rx_data(e_rx),
        .tx_last(e_tx_last), .tx_line(e_tx_line), .tx_irq(e_tx_irq),
        .rx_byte_stb(e_rx_byte_stb), .rx_byte(e_rx_byte), .rx_code(e_rx_code),
        .rx_short(e_rx_short), .rx_hunt(e_rx_hunt)
    );

    hps_port u_f (
        .mclk(mclk), .sys_rst(sys_rst),
        .st_wr(wr && addr == hps_pkg::PORT_F_STATUS_ADDR),
        .ct_wr(wr && addr == hps_pkg::PORT_F_CONTROL_ADDR),
        .tx_wr(wr && addr == hps_pkg::PORT_F_DATA_ADDR),
        .rx_rd(rd && addr == hps_pkg::PORT_F_DATA_ADDR),
        .wdata(wdata), .status(f_st), .control(f_ct), .rx_data(f_rx),
        .tx_last(f_tx_last), .tx_line(f_tx_line), .tx_irq(f_tx_irq),
        .rx_byte_stb(f_rx_byte_stb), .rx_byte(f_rx_byte), .rx_code(f_rx_code),
        .rx_short(f_rx_short), .rx_hunt(f_rx_hunt)
    );

    // Read data stands one cycle after the read strobe; unmapped reads return zero.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                hps_pkg::PORT_E_STATUS_ADDR:  rdata <= e_st;
                hps_pkg::PORT_E_CONTROL_ADDR: rdata <= e_ct;
                hps_pkg::PORT_E_DATA_ADDR:    rdata <= e_rx;
                hps_pkg::PORT_F_STATUS_ADDR:  rdata <= f_st;
                hps_pkg::PORT_F_CONTROL_ADDR: rdata <= f_ct;
                hps_pkg::PORT_F_DATA_ADDR:    rdata <= f_rx;
                default:                      rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule

/* hps_station.sv */
`timescale 1ns/1ps
module hps_station (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // Serial line from the port.
    input  wire logic       tx_line,
    // Deframed bytes toward the port.
    output logic            rx_byte_stb,
    output logic      [7:0] rx_byte,
    output logic      [1:0] rx_code,
    output logic            rx_short,
    // Line observations.
    output int              flag_cnt,
    output int              abort_cnt
);
    logic [7:0] sh_reg;
    int         ones_reg;

    initial begin
        rx_byte_stb = 1'b0;
        rx_byte     = 8'h00;
        rx_code     = 2'h0;
        rx_short    = 1'b0;
    end

    // Byte lines are inverted after the strobe so stale values cannot pass as good.
    task automatic deliver(input logic [7:0] b, input logic [1:0] c, input logic s);
        @(posedge mclk);
        rx_byte_stb <= 1'b1;
        rx_byte     <= b;
        rx_code     <= c;
        rx_short    <= s;
        @(posedge mclk);
        rx_byte_stb <= 1'b0;
        rx_byte     <= ~b;
        rx_code     <= ~c;
        rx_short    <= ~s;
    endtask

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sh_reg    <= 8'h00;
            ones_reg  <= 0;
            flag_cnt  <= 0;
            abort_cnt <= 0;
        end else begin
            sh_reg   <= {tx_line, sh_reg[7:1]};
            ones_reg <= tx_line ? ones_reg + 1 : 0;
            if ({tx_line, sh_reg[7:1]} == hps_pkg::FLAG_PATTERN) flag_cnt <= flag_cnt + 1;
            if (tx_line && ones_reg == 6) abort_cnt <= abort_cnt + 1;
        end
    end
endmodule

/* hdlc_port_status_command_tb.sv */
`timescale 1ns/1ps
module hdlc_port_status_command_tb;
    localparam logic [7:0] EST = hps_pkg::PORT_E_STATUS_ADDR;
    localparam logic [7:0] ECT = hps_pkg::PORT_E_CONTROL_ADDR;
    localparam logic [7:0] EDT = hps_pkg::PORT_E_DATA_ADDR;
    localparam logic [7:0] FST = hps_pkg::PORT_F_STATUS_ADDR;
    localparam logic [7:0] FCT = hps_pkg::PORT_F_CONTROL_ADDR;
    localparam logic [7:0] FDT = hps_pkg::PORT_F_DATA_ADDR;
    typedef logic [31:0] hps_row_t;
    logic       mclk, sys_rst, wr, rd, e_last, e_line, e_irq, e_hunt, f_line, f_irq, f_hunt;
    logic       e_stb, f_stb, e_short, f_short;
    logic [7:0] addr, wdata, rdata, e_byte, f_byte, v;
    logic [1:0] e_code, f_code, cc;
    int         fails, checks_done, f0, i, p;
    hps_row_t   rows [5] = '{{ECT, 8'h0C, ECT, 8'h0C}, {FCT, 8'h08, FCT, 8'h08},
                             {ECT, 8'h4C, ECT, 8'h0C}, {8'h10, 8'h55, 8'h10, 8'h00},
                             {FCT, 8'h0C, FCT, 8'h0C}};
    logic [7:0] hc [3] = '{8'h4C, 8'h8C, 8'h40};
    logic [7:0] hx [3] = '{8'h01, 8'h00, 8'h00};

    hps_top dut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .e_tx_last(e_last), .e_tx_line(e_line), .e_tx_irq(e_irq),
        .e_rx_byte_stb(e_stb), .e_rx_byte(e_byte), .e_rx_code(e_code), .e_rx_short(e_short),
        .e_rx_hunt(e_hunt), .f_tx_last(e_last), .f_tx_line(f_line), .f_tx_irq(f_irq),
        .f_rx_byte_stb(f_stb), .f_rx_byte(f_byte), .f_rx_code(f_code), .f_rx_short(f_short),
        .f_rx_hunt(f_hunt));
    hps_station st_e (.mclk(mclk), .sys_rst(sys_rst), .tx_line(e_line), .rx_byte_stb(e_stb),
        .rx_byte(e_byte), .rx_code(e_code), .rx_short(e_short), .flag_cnt(), .abort_cnt());
    hps_station st_f (.mclk(mclk), .sys_rst(sys_rst), .tx_line(f_line), .rx_byte_stb(f_stb),
        .rx_byte(f_byte), .rx_code(f_code), .rx_short(f_short), .flag_cnt(), .abort_cnt());

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic wrap_up();
        $display("fails %0d checks_done %0d", fails, checks_done);
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic last);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr     <= 1'b1;
        e_last <= last;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata & mk, exp, "register read");
    endtask

    // Waits for the transmit interrupt, then checks cause and an empty buffer.
    task automatic expect_irq(input logic [1:0] c);
        int n;
        n = 0;
        // Step off the edge so that a clear made at that edge is already seen.
        #1;
        while (e_irq !== 1'b1 && n < 400) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({7'h00, e_irq}, 8'h01, "transmit interrupt");
        rd_chk(EST, 8'h0E, {5'h00, c, 1'b0});
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        wrap_up();
    end

    initial begin
        {fails, checks_done} = '0;
        {sys_rst, addr, wdata, wr, rd, e_last} = {1'b1, 19'h0};
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        rd_chk(EST, 8'hFF, 8'h00);
        rd_chk(FST, 8'hFF, 8'h00);
        chk({4'h0, f_irq, f_hunt, e_irq, e_hunt}, 8'h00, "reset outputs");
        foreach (rows[k]) begin
            wr_reg(rows[k][31:24], rows[k][23:16], 1'b0);
            rd_chk(rows[k][15:8], 8'hFF, rows[k][7:0]);
        end
        for (i = 0; i < 3; i++) begin
            wr_reg(ECT, hc[i], 1'b0);
            #1;
            chk({7'h00, e_hunt}, hx[i], "hunt pulse");
            @(posedge mclk);
            #1;
            chk({7'h00, e_hunt}, 8'h00, "hunt once");
        end
        wr_reg(FCT, 8'h4C, 1'b0);
        #1;
        chk({7'h00, f_hunt}, 8'h01, "port f hunt");
        wr_reg(ECT, 8'h0C, 1'b0);
        for (p = 0; p < 2; p++) begin
            for (i = 0; i < 4; i++) begin
                cc = 2'(i);
                if (p == 0) st_e.deliver(8'h30 + 8'(i), cc, cc == 2'h3);
                else st_f.deliver(8'h30 + 8'(i), cc, cc == 2'h3);
                rd_chk(p ? FST : EST, 8'hF1, {1'b1, cc[1], 1'b0, cc[0], 3'h0, cc == 2'h3});
                rd_chk(p ? FDT : EDT, 8'hFF, 8'h30 + 8'(i));
                rd_chk(p ? FST : EST, 8'h80, 8'h00);
            end
        end
        st_e.deliver(8'h5A, 2'h0, 1'b0);
        st_e.deliver(8'h6B, 2'h0, 1'b0);
        rd_chk(EST, 8'h20, 8'h20);
        rd_chk(EDT, 8'hFF, 8'h5A);
        rd_chk(EST, 8'hA0, 8'h00);
        wr_reg(EDT, 8'h11, 1'b0);
        expect_irq(hps_pkg::CAUSE_EMPTY);
        wr_reg(EDT, 8'h22, 1'b1);
        #1;
        chk({7'h00, e_irq}, 8'h00, "cleared by data");
        rd_chk(EST, 8'h08, 8'h08);
        expect_irq(hps_pkg::CAUSE_CRC);
        f0 = st_e.flag_cnt;
        wr_reg(EDT, 8'h44, 1'b1);
        expect_irq(hps_pkg::CAUSE_CRC);
        chk(8'(st_e.flag_cnt - f0), 8'h01, "one flag");
        wr_reg(EST, 8'hA5, 1'b0);
        #1;
        chk({7'h00, e_irq}, 8'h00, "cleared by status");
        expect_irq(hps_pkg::CAUSE_FLAG);
        f0 = st_e.flag_cnt;
        wr_reg(EDT, 8'h11, 1'b1);
        expect_irq(hps_pkg::CAUSE_CRC);
        chk(8'(st_e.flag_cnt >= f0 + 2), 8'h01, "two flags");
        wr_reg(EST, 8'h00, 1'b0);
        expect_irq(hps_pkg::CAUSE_FLAG);
        wr_reg(EST, 8'h00, 1'b0);
        f0 = st_e.abort_cnt;
        wr_reg(ECT, 8'hCC, 1'b0);
        expect_irq(hps_pkg::CAUSE_ABORT);
        chk(8'(st_e.abort_cnt > f0), 8'h01, "abort on line");
        wr_reg(FCT, 8'hCC, 1'b0);
        repeat (20) @(posedge mclk);
        #1;
        chk({7'h00, f_irq}, 8'h01, "port f abort");
        rd_chk(FST, 8'h0E, 8'h04);
        wrap_up();
    end
endmodule
